// File: logic/psf_pressure_sample_fifo.sv
`timescale 1ns/100ps
`default_nettype none
`include "psf_regs.svh"

module psf_pressure_sample_fifo (
	// Clock and reset
	input  wire logic                   sys_clk_in,
	input  wire logic                   srst_in,
	// Register port
	input  wire logic                   reg_wr_in,
	input  wire logic                   reg_rd_in,
	input  wire logic                   reg_next_in,
	input  wire logic [7:0]             reg_addr_in,
	input  wire logic [7:0]             reg_wdata_in,
	output logic      [7:0]             reg_rdata_out,
	output logic                        reg_rvalid_out,
	// Measurement chain
	input  wire logic                   sample_valid_in,
	input  wire logic [`PSF_PRESS_W-1:0] press_in,
	input  wire logic [`PSF_TEMP_W-1:0] temp_in,
	input  wire logic                   interrupt_active_in,
	// Trim storage
	output logic      [1:0]             trim_addr_out,
	input  wire logic [7:0]             trim_data_in,
	output logic      [31:0]            trim_coeff_out,
	output logic                        trim_done_out,
	// Interrupt pin
	output logic                        interrupt_ready_pin_out
);

	import psf_pkg::*;

	// ------------------------------------------------------------------------
	// Decoding helpers
	// ------------------------------------------------------------------------
	function automatic psf_fill_t fill_of(input logic [7:0] ctrl, input logic seen);
		case ({ctrl[`PSF_BC_TRIG_BIT], ctrl[`PSF_BC_MODE_MSB:0]})
			3'h1: fill_of = psf_fill_stop;
			3'h3: fill_of = psf_fill_stream;
			3'h5: fill_of = seen ? psf_fill_stop : psf_fill_off;
			3'h6: fill_of = seen ? psf_fill_stream : psf_fill_off;
			3'h7: fill_of = seen ? psf_fill_stop : psf_fill_stream;
			default: fill_of = psf_fill_off;
		endcase
	endfunction

	function automatic logic [7:0] next_addr(input logic [7:0] a);
		if (a == `PSF_ADDR_BTEMP_HI) begin
			next_addr = `PSF_ADDR_BPRESS_LO;
		end else begin
			next_addr = a + 8'h01;
		end
	endfunction

	// ------------------------------------------------------------------------
	// State
	// ------------------------------------------------------------------------
	psf_phase_t                phase_q, phase_d;
	logic [2:0]                trim_cnt_q, trim_cnt_d;
	logic [31:0]               trim_q, trim_d;
	logic [7:0]                int_ctrl_q, int_ctrl_d;
	logic [7:0]                buf_ctrl_q, buf_ctrl_d;
	logic [7:0]                wmark_q, wmark_d;
	logic [`PSF_PTR_W-1:0]     wr_ptr_q, wr_ptr_d;
	logic [`PSF_PTR_W-1:0]     rd_ptr_q, rd_ptr_d;
	logic [7:0]                count_q, count_d;
	logic                      ovr_q, ovr_d;
	logic                      act_prev_q, act_prev_d;
	logic                      act_seen_q, act_seen_d;
	logic                      drdy_q, drdy_d;
	logic [`PSF_PRESS_W-1:0]   press_q, press_d;
	logic [`PSF_TEMP_W-1:0]    temp_q, temp_d;
	logic [`PSF_ENTRY_W-1:0]   snap_dir_q, snap_dir_d;
	logic [`PSF_ENTRY_W-1:0]   snap_buf_q, snap_buf_d;
	logic [7:0]                burst_addr_q, burst_addr_d;
	logic [7:0]                rdata_q, rdata_d;
	logic                      rvalid_q, rvalid_d;
	logic                      pin_q, pin_d;

	logic                      mem_we;
	logic [`PSF_ENTRY_W-1:0]   mem_rdata;
	psf_fill_t                 fill;
	logic [7:0]                limit;
	logic [7:0]                cnt_base;
	logic                      wmark_flag;
	logic                      full_flag;
	logic                      rd_acc;
	logic [7:0]                rd_addr;
	logic                      pop;
	logic                      overwrite;

	// ------------------------------------------------------------------------
	// Sample storage
	// ------------------------------------------------------------------------
	psf_sample_ram u_ram (
		.sys_clk_in  (sys_clk_in),
		.wr_en_in    (mem_we),
		.wr_addr_in  (wr_ptr_q),
		.wr_data_in  ({temp_in, press_in}),
		.rd_addr_in  (rd_ptr_q),
		.rd_data_out (mem_rdata)
	);

	// ------------------------------------------------------------------------
	// Next-state logic
	// ------------------------------------------------------------------------
	always_comb begin
		phase_d      = phase_q;
		trim_cnt_d   = trim_cnt_q;
		trim_d       = trim_q;
		int_ctrl_d   = int_ctrl_q;
		buf_ctrl_d   = buf_ctrl_q;
		wmark_d      = wmark_q;
		wr_ptr_d     = wr_ptr_q;
		rd_ptr_d     = rd_ptr_q;
		count_d      = count_q;
		ovr_d        = ovr_q;
		act_prev_d   = interrupt_active_in;
		act_seen_d   = act_seen_q;
		drdy_d       = drdy_q;
		press_d      = press_q;
		temp_d       = temp_q;
		snap_dir_d   = snap_dir_q;
		snap_buf_d   = snap_buf_q;
		burst_addr_d = burst_addr_q;
		rdata_d      = 8'h00;
		mem_we       = 1'b0;
		overwrite    = 1'b0;

		// Trim bytes arrive one cycle after their address is presented.
		case (phase_q)
			psf_phase_trim: begin
				trim_cnt_d = trim_cnt_q + 3'h1;
				if (trim_cnt_q != 3'h0) begin
					trim_d = {trim_data_in, trim_q[31:8]};
				end
				if (trim_cnt_q == `PSF_TRIM_BYTES) begin
					phase_d = psf_phase_run;
				end
			end
			default: begin
				phase_d = psf_phase_run;
			end
		endcase

		fill = fill_of(buf_ctrl_q, act_seen_q);
		if (buf_ctrl_q[`PSF_BC_LIMIT_BIT] && (wmark_q[6:0] != 7'h00)) begin
			limit = {1'b0, wmark_q[6:0]};
		end else begin
			limit = `PSF_DEPTH_COUNT;
		end
		wmark_flag = (wmark_q[6:0] != 7'h00) && (count_q >= {1'b0, wmark_q[6:0]});
		full_flag  = (count_q >= limit);

		if (interrupt_active_in && !act_prev_q) begin
			act_seen_d = 1'b1;
		end

		// Register reads: a burst step continues from the stored address.
		rd_acc  = reg_rd_in | reg_next_in;
		rd_addr = reg_rd_in ? reg_addr_in : burst_addr_q;
		pop     = 1'b0;
		if (rd_acc) begin
			burst_addr_d = next_addr(rd_addr);
			if (rd_addr == `PSF_ADDR_INT_CTRL) begin
				rdata_d = int_ctrl_q;
			end else if (rd_addr == `PSF_ADDR_BUF_CTRL) begin
				rdata_d = buf_ctrl_q;
			end else if (rd_addr == `PSF_ADDR_BUF_WM) begin
				rdata_d = wmark_q;
			end else if (rd_addr == `PSF_ADDR_BUF_LEVEL) begin
				rdata_d = count_q;
			end else if (rd_addr == `PSF_ADDR_BUF_FLAGS) begin
				rdata_d[`PSF_FL_WM_BIT]   = wmark_flag;
				rdata_d[`PSF_FL_OVR_BIT]  = ovr_q;
				rdata_d[`PSF_FL_FULL_BIT] = full_flag;
				ovr_d = 1'b0;
			end else if (rd_addr == `PSF_ADDR_PRESS_LO) begin
				snap_dir_d = {temp_q, press_q};
				rdata_d    = press_q[7:0];
			end else if (rd_addr == `PSF_ADDR_PRESS_MID) begin
				rdata_d = snap_dir_q[15:8];
			end else if (rd_addr == `PSF_ADDR_PRESS_HI) begin
				rdata_d = snap_dir_q[23:16];
			end else if (rd_addr == `PSF_ADDR_TEMP_LO) begin
				snap_dir_d[39:24] = temp_q;
				rdata_d           = temp_q[7:0];
			end else if (rd_addr == `PSF_ADDR_TEMP_HI) begin
				rdata_d = snap_dir_q[39:32];
				drdy_d  = 1'b0;
			end else if (rd_addr == `PSF_ADDR_BPRESS_LO) begin
				snap_buf_d = mem_rdata;
				rdata_d    = mem_rdata[7:0];
			end else if (rd_addr == `PSF_ADDR_BPRESS_MID) begin
				rdata_d = snap_buf_q[15:8];
			end else if (rd_addr == `PSF_ADDR_BPRESS_HI) begin
				rdata_d = snap_buf_q[23:16];
			end else if (rd_addr == `PSF_ADDR_BTEMP_LO) begin
				rdata_d = snap_buf_q[31:24];
			end else if (rd_addr == `PSF_ADDR_BTEMP_HI) begin
				rdata_d = snap_buf_q[39:32];
				pop     = (count_q != 8'h00);
			end else begin
				rdata_d = 8'h00;
			end
		end

		// A new result replaces the direct outputs; it enters the buffer while filling is on and there is room, or in stream mode.
		cnt_base = count_q - {7'h00, pop};
		if ((phase_q == psf_phase_run) && sample_valid_in) begin
			press_d = press_in;
			temp_d  = temp_in;
			drdy_d  = 1'b1;
			if (fill != psf_fill_off) begin
				if (cnt_base < limit) begin
					mem_we   = 1'b1;
					cnt_base = cnt_base + 8'h01;
				end else if (fill == psf_fill_stream) begin
					mem_we    = 1'b1;
					overwrite = 1'b1;
					ovr_d     = 1'b1;
				end
			end
		end
		count_d  = cnt_base;
		rd_ptr_d = rd_ptr_q + {6'h00, pop} + {6'h00, overwrite};
		if (mem_we) begin
			wr_ptr_d = wr_ptr_q + 7'h01;
		end

		// Register writes.
		if (reg_wr_in) begin
			if (reg_addr_in == `PSF_ADDR_INT_CTRL) begin
				int_ctrl_d = reg_wdata_in;
			end else if (reg_addr_in == `PSF_ADDR_BUF_CTRL) begin
				buf_ctrl_d = reg_wdata_in;
				if (reg_wdata_in[`PSF_BC_MODE_MSB:0] == 2'b00) begin
					act_seen_d = 1'b0;
				end
			end else if (reg_addr_in == `PSF_ADDR_BUF_WM) begin
				wmark_d = {1'b0, reg_wdata_in[6:0]};
			end
		end

		// Bypass, mode 2 without trigger, or triggered modes 1 and 2 still waiting, hold the buffer empty.
		if (fill == psf_fill_off) begin
			wr_ptr_d = {`PSF_PTR_W{1'b0}};
			rd_ptr_d = {`PSF_PTR_W{1'b0}};
			count_d  = 8'h00;
			ovr_d    = 1'b0;
		end

		pin_d = (int_ctrl_q[`PSF_IC_DRDY_BIT] & drdy_q)
		      | (int_ctrl_q[`PSF_IC_OVR_BIT] & ovr_q)
		      | (int_ctrl_q[`PSF_IC_WM_BIT] & wmark_flag)
		      | (int_ctrl_q[`PSF_IC_FULL_BIT] & full_flag);
		rvalid_d = rd_acc;
	end

	// ------------------------------------------------------------------------
	// Registers
	// ------------------------------------------------------------------------
	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			phase_q      <= psf_phase_trim;
			trim_cnt_q   <= 3'h0;
			trim_q       <= 32'h0000_0000;
			int_ctrl_q   <= `PSF_CTRL_RESET;
			buf_ctrl_q   <= `PSF_CTRL_RESET;
			wmark_q      <= `PSF_CTRL_RESET;
			wr_ptr_q     <= {`PSF_PTR_W{1'b0}};
			rd_ptr_q     <= {`PSF_PTR_W{1'b0}};
			count_q      <= 8'h00;
			ovr_q        <= 1'b0;
			act_prev_q   <= 1'b0;
			act_seen_q   <= 1'b0;
			drdy_q       <= 1'b0;
			press_q      <= {`PSF_PRESS_W{1'b0}};
			temp_q       <= {`PSF_TEMP_W{1'b0}};
			snap_dir_q   <= {`PSF_ENTRY_W{1'b0}};
			snap_buf_q   <= {`PSF_ENTRY_W{1'b0}};
			burst_addr_q <= 8'h00;
			rdata_q      <= 8'h00;
			rvalid_q     <= 1'b0;
			pin_q        <= 1'b0;
		end else begin
			phase_q      <= phase_d;
			trim_cnt_q   <= trim_cnt_d;
			trim_q       <= trim_d;
			int_ctrl_q   <= int_ctrl_d;
			buf_ctrl_q   <= buf_ctrl_d;
			wmark_q      <= wmark_d;
			wr_ptr_q     <= wr_ptr_d;
			rd_ptr_q     <= rd_ptr_d;
			count_q      <= count_d;
			ovr_q        <= ovr_d;
			act_prev_q   <= act_prev_d;
			act_seen_q   <= act_seen_d;
			drdy_q       <= drdy_d;
			press_q      <= press_d;
			temp_q       <= temp_d;
			snap_dir_q   <= snap_dir_d;
			snap_buf_q   <= snap_buf_d;
			burst_addr_q <= burst_addr_d;
			rdata_q      <= rdata_d;
			rvalid_q     <= rvalid_d;
			pin_q        <= pin_d;
		end
	end

	assign reg_rdata_out           = rdata_q;
	assign reg_rvalid_out          = rvalid_q;
	assign trim_addr_out           = trim_cnt_q[1:0];
	assign trim_coeff_out          = trim_q;
	assign trim_done_out           = (phase_q == psf_phase_run);
	assign interrupt_ready_pin_out = pin_q;

endmodule

`default_nettype wire

// File: logic/psf_regs.svh
`ifndef PSF_REGS_SVH
`define PSF_REGS_SVH

// ----------------------------------------------------------------------------
// Register offsets
// ----------------------------------------------------------------------------
`define PSF_ADDR_INT_CTRL   8'h12
`define PSF_ADDR_BUF_CTRL   8'h13
`define PSF_ADDR_BUF_WM     8'h14
`define PSF_ADDR_BUF_LEVEL  8'h25
`define PSF_ADDR_BUF_FLAGS  8'h26
`define PSF_ADDR_PRESS_LO   8'h28
`define PSF_ADDR_PRESS_MID  8'h29
`define PSF_ADDR_PRESS_HI   8'h2a
`define PSF_ADDR_TEMP_LO    8'h2b
`define PSF_ADDR_TEMP_HI    8'h2c
`define PSF_ADDR_BPRESS_LO  8'h78
`define PSF_ADDR_BPRESS_MID 8'h79
`define PSF_ADDR_BPRESS_HI  8'h7a
`define PSF_ADDR_BTEMP_LO   8'h7b
`define PSF_ADDR_BTEMP_HI   8'h7c

// ----------------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------------
`define PSF_BC_MODE_MSB     1
`define PSF_BC_TRIG_BIT     2
`define PSF_BC_LIMIT_BIT    3
`define PSF_IC_DRDY_BIT     2
`define PSF_IC_OVR_BIT      3
`define PSF_IC_WM_BIT       4
`define PSF_IC_FULL_BIT     5
`define PSF_FL_WM_BIT       7
`define PSF_FL_OVR_BIT      6
`define PSF_FL_FULL_BIT     5

// ----------------------------------------------------------------------------
// Reset values and sizes
// ----------------------------------------------------------------------------
`define PSF_CTRL_RESET      8'h00
`define PSF_DEPTH_COUNT     8'h80
`define PSF_PTR_W           7
`define PSF_ENTRY_W         40
`define PSF_PRESS_W         24
`define PSF_TEMP_W          16
`define PSF_TRIM_BYTES      3'h4

`endif

// File: logic/psf_pkg.sv
`default_nettype none

package psf_pkg;

	typedef enum logic [1:0] {
		psf_fill_off    = 2'b00,
		psf_fill_stop   = 2'b01,
		psf_fill_stream = 2'b10
	} psf_fill_t;

	typedef enum logic {
		psf_phase_trim = 1'b0,
		psf_phase_run  = 1'b1
	} psf_phase_t;

endpackage

`default_nettype wire

// File: logic/psf_sample_ram.sv
`timescale 1ns/100ps
`default_nettype none
`include "psf_regs.svh"

module psf_sample_ram (
	// Clock
	input  wire logic                    sys_clk_in,
	// Write side
	input  wire logic                    wr_en_in,
	input  wire logic [`PSF_PTR_W-1:0]   wr_addr_in,
	input  wire logic [`PSF_ENTRY_W-1:0] wr_data_in,
	// Read side
	input  wire logic [`PSF_PTR_W-1:0]   rd_addr_in,
	output logic      [`PSF_ENTRY_W-1:0] rd_data_out
);

	logic [`PSF_ENTRY_W-1:0] mem [0:(1<<`PSF_PTR_W)-1];

	// Storage has no reset; the pointers and the level count say which entries are live.
	always_ff @(posedge sys_clk_in) begin
		if (wr_en_in) begin
			mem[wr_addr_in] <= wr_data_in;
		end
		rd_data_out <= mem[rd_addr_in];
	end

endmodule

`default_nettype wire

// File: tb/psf_trim_rom.sv
`timescale 1ns/100ps
`default_nettype none

module psf_trim_rom (
	// Clock
	input  wire logic       sys_clk_in,
	// Trim byte lookup
	input  wire logic [1:0] trim_addr_in,
	output logic      [7:0] trim_data_out
);
	// The storage answers one cycle after the address, as slow as the block allows.
	always_ff @(posedge sys_clk_in) begin
		trim_data_out <= 8'ha0 + {6'h00, trim_addr_in};
	end
endmodule

`default_nettype wire

// File: tb/psf_fifo_props.sv
`timescale 1ns/100ps
`default_nettype none

module psf_fifo_props (
	// Clock and reset
	input  wire logic       sys_clk_in,
	input  wire logic       srst_in,
	// Register port
	input  wire logic       reg_wr_in,
	input  wire logic       reg_rd_in,
	input  wire logic       reg_next_in,
	input  wire logic [7:0] reg_addr_in,
	input  wire logic [7:0] reg_wdata_in,
	input  wire logic [7:0] reg_rdata_out,
	input  wire logic       reg_rvalid_out,
	// Trim and pin
	input  wire logic [1:0] trim_addr_out,
	input  wire logic       trim_done_out,
	input  wire logic       interrupt_ready_pin_out
);
	// ------------------------------------------------------------------
	// Mirrors of the writable registers
	// ------------------------------------------------------------------
	logic [7:0] ic_q;
	logic [7:0] ic_d;
	logic [7:0] bc_q;
	logic [7:0] bc_d;
	logic [7:0] wm_q;
	logic [7:0] wm_d;

	always_comb begin
		ic_d = ic_q;
		bc_d = bc_q;
		wm_d = wm_q;
		if (reg_wr_in && reg_addr_in == 8'h12) begin
			ic_d = reg_wdata_in;
		end
		if (reg_wr_in && reg_addr_in == 8'h13) begin
			bc_d = reg_wdata_in;
		end
		if (reg_wr_in && reg_addr_in == 8'h14) begin
			wm_d = {1'b0, reg_wdata_in[6:0]};
		end
	end

	always_ff @(posedge sys_clk_in) begin
		if (srst_in) begin
			ic_q <= 8'h00;
			bc_q <= 8'h00;
			wm_q <= 8'h00;
		end else begin
			ic_q <= ic_d;
			bc_q <= bc_d;
			wm_q <= wm_d;
		end
	end

	// ------------------------------------------------------------------
	// Properties
	// ------------------------------------------------------------------
	default clocking cb @(posedge sys_clk_in); endclocking
	default disable iff (srst_in);

	sequence rd_at(logic [7:0] a);
		reg_rd_in && reg_addr_in == a;
	endsequence
	// Two settled cycles of bypass give the clear time to land first.
	sequence in_bypass;
		(bc_q[1:0] == 2'b00) [*2];
	endsequence
	sequence pin_quiet;
		(ic_q[5:2] == 4'h0) [*3];
	endsequence

	rvalid_follow_a: assert property ((reg_rd_in || reg_next_in) |=> reg_rvalid_out)
		else $error("read strobe got no valid one cycle later");
	rvalid_cause_a: assert property (reg_rvalid_out |-> $past(reg_rd_in) || $past(reg_next_in))
		else $error("read valid without a strobe");
	rdata_idle_a: assert property (!reg_rvalid_out |-> reg_rdata_out == 8'h00)
		else $error("read data not zero while idle");
	trim_start_a: assert property ($fell(srst_in) |-> trim_addr_out == 2'h0 && !trim_done_out)
		else $error("trim load did not start from byte zero");
	trim_done_a: assert property ($fell(srst_in) |-> !trim_done_out [*5] ##1 trim_done_out)
		else $error("trim load length wrong");
	trim_hold_a: assert property (trim_done_out |=> trim_done_out)
		else $error("trim done dropped");
	ctrl_back_a: assert property (rd_at(8'h13) |=> reg_rdata_out == bc_q)
		else $error("buffer control read back wrong");
	wmark_back_a: assert property (rd_at(8'h14) |=> reg_rdata_out == wm_q)
		else $error("watermark read back wrong");
	wmark_zero_a: assert property (rd_at(8'h26) ##0 wm_q == 8'h00 |=> !reg_rdata_out[7])
		else $error("watermark flag set with level zero");
	bypass_empty_a: assert property (in_bypass ##0 rd_at(8'h25) |=> reg_rdata_out == 8'h00)
		else $error("buffer not empty in bypass");
	pin_quiet_a: assert property (pin_quiet |-> !interrupt_ready_pin_out)
		else $error("pin high with every source disabled");
	unmapped_zero_a: assert property (rd_at(8'h00) |=> reg_rdata_out == 8'h00)
		else $error("unmapped read not zero");
endmodule

bind psf_pressure_sample_fifo psf_fifo_props u_props (
	.sys_clk_in              (sys_clk_in),
	.srst_in                 (srst_in),
	.reg_wr_in               (reg_wr_in),
	.reg_rd_in               (reg_rd_in),
	.reg_next_in             (reg_next_in),
	.reg_addr_in             (reg_addr_in),
	.reg_wdata_in            (reg_wdata_in),
	.reg_rdata_out           (reg_rdata_out),
	.reg_rvalid_out          (reg_rvalid_out),
	.trim_addr_out           (trim_addr_out),
	.trim_done_out           (trim_done_out),
	.interrupt_ready_pin_out (interrupt_ready_pin_out)
);

`default_nettype wire

// File: tb/psf_pressure_sample_fifo_test.sv
`timescale 1ns/100ps
`default_nettype none

module psf_pressure_sample_fifo_test;
	logic        sys_clk_in = 0;
	logic        srst_in = 1;
	logic        reg_wr_in = 0;
	logic        reg_rd_in = 0;
	logic        reg_next_in = 0;
	logic        sample_valid_in = 0;
	logic        interrupt_active = 0;
	logic [7:0]  reg_addr_in = 0;
	logic [7:0]  reg_wdata_in = 0;
	logic [7:0]  reg_rdata_out;
	logic [7:0]  trim_data;
	logic [1:0]  trim_addr;
	logic [31:0] trim_coeff;
	logic        reg_rvalid_out;
	logic        trim_done;
	logic        pin;
	logic [23:0] press_in = 0;
	logic [15:0] temp_in = 0;
	logic [7:0]  seq = 0;
	int          bad_count = 0;
	int          checks_done = 0;

	always #25 sys_clk_in = ~sys_clk_in;

	psf_pressure_sample_fifo uut (
		.sys_clk_in(sys_clk_in), .srst_in(srst_in), .reg_wr_in(reg_wr_in),
		.reg_rd_in(reg_rd_in), .reg_next_in(reg_next_in), .reg_addr_in(reg_addr_in),
		.reg_wdata_in(reg_wdata_in), .reg_rdata_out(reg_rdata_out),
		.reg_rvalid_out(reg_rvalid_out), .sample_valid_in(sample_valid_in),
		.press_in(press_in), .temp_in(temp_in), .interrupt_active_in(interrupt_active),
		.trim_addr_out(trim_addr), .trim_data_in(trim_data), .trim_coeff_out(trim_coeff),
		.trim_done_out(trim_done), .interrupt_ready_pin_out(pin));
	psf_trim_rom rom (.sys_clk_in(sys_clk_in), .trim_addr_in(trim_addr),
		.trim_data_out(trim_data));

	// Bytes 0, 1 and 3 of an entry move with the sequence number; bytes 2 and 4 stay fixed.
	function automatic logic [39:0] ent(input logic [7:0] s);
		return {8'h09, s + 8'h40, 8'h3f, s + 8'h20, s};
	endfunction
	task chk(input logic [39:0] seen, input logic [39:0] exp);
		checks_done++;
		if (seen !== exp) begin
			bad_count++;
			$display("MISMATCH at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask
	task wr(input logic [7:0] a, input logic [7:0] d);
		@(negedge sys_clk_in); reg_wr_in = 1; reg_addr_in = a; reg_wdata_in = d;
		@(negedge sys_clk_in); reg_wr_in = 0;
	endtask
	task rd(input logic [7:0] a, output logic [7:0] d);
		@(negedge sys_clk_in); reg_rd_in = 1; reg_addr_in = a;
		@(negedge sys_clk_in); reg_rd_in = 0; d = reg_rdata_out;
	endtask
	task rdchk(input logic [7:0] a, input logic [7:0] exp);
		logic [7:0] b;
		rd(a, b);
		chk(b, exp);
	endtask
	task burst(output logic [39:0] e);
		logic [7:0] b;
		rd(8'h78, b);
		e[7:0] = b;
		reg_next_in = 1;
		for (int i = 1; i < 5; i++) begin
			@(negedge sys_clk_in); e[i*8 +: 8] = reg_rdata_out;
			if (i == 4) reg_next_in = 0;
		end
	endtask
	task push(input int n);
		for (int i = 0; i < n; i++) begin
			@(negedge sys_clk_in); seq++; sample_valid_in = 1;
			{temp_in, press_in} = ent(seq);
		end
		@(negedge sys_clk_in); sample_valid_in = 0;
		repeat (2) @(negedge sys_clk_in);
	endtask

	task t_init;
		for (int i = 0; i < 20 && trim_done !== 1'b1; i++) @(negedge sys_clk_in);
		chk(trim_done, 1);
		chk(trim_coeff, 32'ha3a2a1a0);
		rdchk(8'h12, 8'h00);
		rdchk(8'h13, 8'h00);
		rdchk(8'h14, 8'h00);
		rdchk(8'h00, 8'h00);
		wr(8'h14, 8'hff);
		rdchk(8'h14, 8'h7f);
		$display("test init done");
	endtask
	task t_direct;
		logic [39:0] e;
		logic [7:0] b;
		wr(8'h12, 8'h04);
		push(1);
		chk(pin, 1);
		e = ent(seq);
		for (int k = 0; k < 5; k++) rdchk(8'h28 + k, e[k*8 +: 8]);
		repeat (2) @(negedge sys_clk_in);
		chk(pin, 0);
		wr(8'h12, 8'h00);
		rd(8'h28, b);
		push(1);
		rdchk(8'h29, e[15:8]);
		$display("test direct done");
	endtask
	task t_fifo;
		logic [39:0] e;
		logic [7:0] s0;
		logic [7:0] b;
		wr(8'h13, 8'h00); wr(8'h14, 8'h03); wr(8'h13, 8'h01);
		s0 = seq + 1;
		push(3);
		rdchk(8'h25, 8'h03);
		rd(8'h26, b);
		chk(b[7:6], 2'b10);
		wr(8'h12, 8'h10);
		@(negedge sys_clk_in);
		chk(pin, 1);
		burst(e);
		chk(e, ent(s0));
		repeat (2) @(negedge sys_clk_in);
		reg_next_in = 1; @(negedge sys_clk_in); reg_next_in = 0;
		chk(reg_rdata_out, ent(s0 + 1) & 40'hff);
		rdchk(8'h25, 8'h02);
		rd(8'h26, b);
		chk(b[7], 0);
		chk(pin, 0);
		wr(8'h12, 8'h00);
		push(127);
		rdchk(8'h25, 8'h80);
		rd(8'h26, b);
		chk(b[7:5], 3'b101);
		wr(8'h13, 8'h00); wr(8'h13, 8'h09);
		push(5);
		rdchk(8'h25, 8'h03);
		wr(8'h14, 8'h00);
		rd(8'h26, b);
		chk(b[7], 1'b0);
		$display("test fifo done");
	endtask
	task t_stream;
		logic [39:0] e;
		logic [7:0] s0;
		logic [7:0] b;
		wr(8'h13, 8'h00);
		rdchk(8'h25, 8'h00);
		wr(8'h13, 8'h03);
		s0 = seq + 1;
		push(129);
		rdchk(8'h25, 8'h80);
		wr(8'h12, 8'h08);
		@(negedge sys_clk_in);
		chk(pin, 1);
		rd(8'h26, b);
		chk(b[6], 1);
		rd(8'h26, b);
		chk(b[6], 0);
		chk(pin, 0);
		wr(8'h12, 8'h00);
		burst(e);
		chk(e, ent(s0 + 1));
		$display("test stream done");
	endtask
	task t_trig;
		logic [7:0] codes [7] = '{8'h00, 8'h04, 8'h01, 8'h03, 8'h05, 8'h06, 8'h07};
		logic [7:0] pre [7] = '{0, 0, 1, 1, 0, 0, 1};
		logic [7:0] post [7] = '{0, 0, 2, 2, 1, 1, 2};
		for (int i = 0; i < 7; i++) begin
			wr(8'h13, 8'h00); wr(8'h13, codes[i]);
			push(1);
			rdchk(8'h25, pre[i]);
			@(negedge sys_clk_in); interrupt_active = 1;
			push(1);
			rdchk(8'h25, post[i]);
			interrupt_active = 0;
		end
		$display("test trig done");
	endtask

	task end_sim;
		$display("checks %0d mismatches %0d", checks_done, bad_count);
		if (bad_count == 0 && checks_done > 0) begin
			$display("*** PASS ***");
		end else begin
			$display("*** FAIL ***");
		end
		$finish;
	endtask

	initial begin
		repeat (6) @(negedge sys_clk_in);
		srst_in = 0;
		t_init;
		t_direct;
		t_fifo;
		t_stream;
		t_trig;
		end_sim;
	end
	// The tests need about 500 cycles; a fortyfold margin still ends quickly.
	initial begin
		#1000000;
		bad_count++;
		end_sim;
	end
endmodule

`default_nettype wire
